// ---- hdl/srasl_dev.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// RL1: host makes clock, select and input
// RL2: device is slave, drives serial output
// RL3: clock idles low between transfers
// RL4: select fall restarts bit tracking
// RL5: 27 header, 5 turnaround, 8 data
// RL6: burst continues while select stays low
// RL7: address increments every eight data bits
// RL8: all fields most significant bit first
// RL9: input sampled on clock rising edge
// RL10: output changes on clock falling edge
// RL11: 011 reads, 010 writes, nothing else
// RL12: upper eight address bits ignored
// RL13: turnaround input bits ignored
// RL14: port mode from strap at reset release
// RL15: whole register space reachable
// RL16: output undriven while deselected
// RL17: write only complete bytes
module srasl_dev #(
	parameter int NREGS = 65536
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// serial link
	srasl_if.dev link,
	// strap and mode
	input wire logic [1:0] mode_strap_i,
	output logic [1:0] port_mode_o,
	// register file observation
	output logic wr_pulse_o,
	output logic [15:0] wr_addr_o,
	output logic [7:0] wr_data_o
);
	import srasl_pkg::*;

	// ----------------------------------------
	// synchronisers
	// ----------------------------------------
	logic [2:0] s1, s2;
	logic clk_d, csn_d;
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			// idle levels of clock, select and input: no false edge
			s1 <= 3'h2;
			s2 <= 3'h2;
		end else begin
			s1 <= {link.ser_clk, link.chip_sel_n, link.ser_in};
			s2 <= s1;
		end
	end
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			clk_d <= 1'b0;
			csn_d <= 1'b1;
		end else begin
			clk_d <= s2[2];
			csn_d <= s2[1];
		end
	end
	logic sclk, csn, din, rise, fall, cs_fall;
	assign sclk = s2[2];
	assign csn = s2[1];
	assign din = s2[0];
	// RL16 deselected ignore
	assign rise = sclk && !clk_d && !csn;
	assign fall = !sclk && clk_d && !csn;
	assign cs_fall = !csn && csn_d;

	// ----------------------------------------
	// strap capture
	// ----------------------------------------
	logic strap_done;
	logic [1:0] strap_s1, strap_s2;
	// no reset here: the strap must be settled when reset lets go
	always_ff @(posedge clk_i) begin
		strap_s1 <= mode_strap_i;
		strap_s2 <= strap_s1;
	end
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			strap_done <= 1'b0;
			port_mode_o <= MODE_SERIAL;
		// RL14 strap sampled once
		end else if (!strap_done) begin
			strap_done <= 1'b1;
			port_mode_o <= strap_s2;
		end
	end
	logic active;
	assign active = strap_done && (port_mode_o == MODE_SERIAL);

	// ----------------------------------------
	// register space
	// ----------------------------------------
	// RL15 full space
	logic [7:0] regs [NREGS];

	// ----------------------------------------
	// receive side
	// ----------------------------------------
	logic [5:0] bitcnt;
	logic [2:0] dbit;
	logic [HDR_BITS-1:0] hdr;
	logic [7:0] rx;
	logic [15:0] addr;
	logic in_data;
	logic is_rd, is_wr;
	// RL5 data after header and turnaround
	assign in_data = bitcnt == 6'(PRE_BITS);
	// RL11 command decode
	assign is_rd = hdr[HDR_BITS-1 -: CMD_BITS] == CMD_READ;
	assign is_wr = hdr[HDR_BITS-1 -: CMD_BITS] == CMD_WRITE;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			bitcnt <= 6'h00;
			dbit <= 3'h0;
			hdr <= '0;
			rx <= 8'h00;
			addr <= 16'h0000;
		// RL4 restart on select fall
		end else if (cs_fall) begin
			bitcnt <= 6'h00;
			dbit <= 3'h0;
		// RL9 sample on rise
		end else if (rise && active) begin
			if (bitcnt < 6'(HDR_BITS)) begin
				// RL8 msb first
				hdr <= {hdr[HDR_BITS-2:0], din};
				bitcnt <= bitcnt + 6'h01;
			end else if (!in_data) begin
				// RL13 turnaround ignored
				bitcnt <= bitcnt + 6'h01;
				// RL12 low sixteen only
				addr <= hdr[REG_ADDR_BITS-1:0];
			end else begin
				rx <= {rx[6:0], din};
				dbit <= dbit + 3'h1;
				// RL7 step address per byte
				if (dbit == 3'h7)
					addr <= addr + 16'h0001;
			end
		end
	end

	// RL17 whole bytes only
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wr_pulse_o <= 1'b0;
			wr_addr_o <= 16'h0000;
			wr_data_o <= RESET_DATA;
		end else begin
			wr_pulse_o <= 1'b0;
			if (rise && active && in_data && is_wr && dbit == 3'h7) begin
				wr_pulse_o <= 1'b1;
				wr_addr_o <= addr;
				wr_data_o <= {rx[6:0], din};
			end
		end
	end
	always_ff @(posedge clk_i) begin
		if (rise && active && in_data && is_wr && dbit == 3'h7)
			regs[addr] <= {rx[6:0], din};
	end

	// ----------------------------------------
	// transmit side
	// ----------------------------------------
	logic [7:0] tx;
	logic [2:0] tbit;
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tx <= 8'h00;
			tbit <= 3'h0;
			link.ser_out <= 1'b0;
		end else if (cs_fall) begin
			tbit <= 3'h0;
			link.ser_out <= 1'b0;
		// RL10 change on fall
		end else if (fall && active && in_data && is_rd) begin
			// RL8 msb first out
			if (tbit == 3'h0) begin
				tx <= {regs[addr][6:0], 1'b0};
				link.ser_out <= regs[addr][7];
			end else begin
				tx <= {tx[6:0], 1'b0};
				link.ser_out <= tx[7];
			end
			tbit <= tbit + 3'h1;
		end
	end
	// RL2 slave drives output; RL16 released when deselected
	// in_data still holds the last frame in the select-fall cycle
	assign link.ser_out_oe = active && !csn && !cs_fall && in_data && is_rd;
endmodule : srasl_dev

// ---- hdl/srasl_pkg.sv ----
package srasl_pkg;
	// ----------------------------------------
	// frame layout
	// ----------------------------------------
	localparam int CMD_BITS = 3;
	localparam int ADDR_BITS = 24;
	localparam int REG_ADDR_BITS = 16;
	localparam int TURN_BITS = 5;
	localparam int DATA_BITS = 8;
	localparam int HDR_BITS = CMD_BITS + ADDR_BITS;
	localparam int PRE_BITS = HDR_BITS + TURN_BITS;
	localparam logic [2:0] CMD_READ = 3'h3;
	localparam logic [2:0] CMD_WRITE = 3'h2;
	// ----------------------------------------
	// host clock divider and strap codes
	// ----------------------------------------
	localparam int HOST_HALF_DIV = 4;
	localparam logic [1:0] MODE_SERIAL = 2'h0;
	localparam logic [1:0] MODE_TWO_WIRE = 2'h1;
	localparam logic [1:0] MODE_STATION = 2'h2;
	localparam logic [7:0] RESET_DATA = 8'h00;
	typedef enum {SRASL_IDLE, SRASL_SEL, SRASL_SHIFT, SRASL_DESEL} srasl_host_state_t;
endpackage : srasl_pkg

// ---- hdl/srasl_if.sv ----
`timescale 1ns/1ps
interface srasl_if;
	logic ser_clk;
	logic chip_sel_n;
	logic ser_in;
	logic ser_out;
	logic ser_out_oe;
	// resolved line level; floats high in this model when nobody drives
	wire ser_out_line;
	assign ser_out_line = ser_out_oe ? ser_out : 1'b1;
	modport dev (input ser_clk, input chip_sel_n, input ser_in,
		output ser_out, output ser_out_oe);
	modport host (output ser_clk, output chip_sel_n, output ser_in,
		input ser_out_line);
endinterface : srasl_if

// ---- hdl/srasl_host.sv ----
`timescale 1ns/1ps
module srasl_host (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// serial link
	srasl_if.host link,
	// user request
	input wire logic req_i,
	input wire logic wr_i,
	input wire logic [15:0] addr_i,
	input wire logic [3:0] nbytes_i,
	input wire logic [7:0] wdata_i,
	output logic wdata_take_o,
	output logic busy_o,
	output logic rdata_valid_o,
	output logic [7:0] rdata_o
);
	import srasl_pkg::*;

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	srasl_host_state_t state;
	logic [2:0] div;
	logic phase;
	logic [5:0] bitcnt;
	logic [2:0] dbit;
	logic [3:0] left;
	logic wr;
	logic [PRE_BITS-1:0] hdr;
	logic [7:0] sh, rsh;
	logic in2, in1;
	logic tick;
	assign tick = div == 3'(HOST_HALF_DIV - 1);
	assign busy_o = state != SRASL_IDLE;
	assign wdata_take_o = state == SRASL_IDLE && req_i && wr_i;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			in1 <= 1'b0;
			in2 <= 1'b0;
		end else begin
			in1 <= link.ser_out_line;
			in2 <= in1;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state <= SRASL_IDLE;
			div <= 3'h0;
			phase <= 1'b0;
			bitcnt <= 6'h00;
			dbit <= 3'h0;
			left <= 4'h0;
			wr <= 1'b0;
			hdr <= '0;
			sh <= 8'h00;
			rsh <= 8'h00;
			link.ser_clk <= 1'b0;
			link.chip_sel_n <= 1'b1;
			link.ser_in <= 1'b0;
			rdata_valid_o <= 1'b0;
			rdata_o <= 8'h00;
		end else begin
			rdata_valid_o <= 1'b0;
			div <= tick ? 3'h0 : div + 3'h1;
			case (state)
			SRASL_IDLE: begin
				// RL3 clock parked low
				link.ser_clk <= 1'b0;
				if (req_i) begin
					wr <= wr_i;
					left <= (nbytes_i == 4'h0) ? 4'h1 : nbytes_i;
					// RL11 RL12 RL5 header with zero upper address
					hdr <= {wr_i ? CMD_WRITE : CMD_READ, 8'h00, addr_i,
						5'h00};
					sh <= wdata_i;
					bitcnt <= 6'h00;
					dbit <= 3'h0;
					phase <= 1'b0;
					div <= 3'h0;
					// RL4 select falls to start
					link.chip_sel_n <= 1'b0;
					state <= SRASL_SEL;
				end
			end
			SRASL_SEL: if (tick) begin
				// RL8 msb first
				link.ser_in <= hdr[PRE_BITS-1];
				hdr <= {hdr[PRE_BITS-2:0], 1'b0};
				state <= SRASL_SHIFT;
			end
			SRASL_SHIFT: if (tick) begin
				phase <= !phase;
				// RL1 host drives clock
				link.ser_clk <= !phase;
				// read data is taken at our falling edge: device answer
				// plus our synchroniser lag exceeds a half period
				if (phase) begin
					if (bitcnt < 6'(PRE_BITS)) begin
						bitcnt <= bitcnt + 6'h01;
						if (bitcnt == 6'(PRE_BITS - 1))
							link.ser_in <= wr ? sh[7] : 1'b0;
						else
							link.ser_in <= hdr[PRE_BITS-1];
						hdr <= {hdr[PRE_BITS-2:0], 1'b0};
						if (bitcnt == 6'(PRE_BITS - 1) && wr)
							sh <= {sh[6:0], 1'b0};
					end else begin
						dbit <= dbit + 3'h1;
						rsh <= {rsh[6:0], in2};
						link.ser_in <= wr ? sh[7] : 1'b0;
						sh <= {sh[6:0], 1'b0};
						if (dbit == 3'h7) begin
							if (!wr) begin
								rdata_valid_o <= 1'b1;
								rdata_o <= {rsh[6:0], in2};
							end
							// RL6 burst keeps select low
							left <= left - 4'h1;
							sh <= {wdata_i[6:0], 1'b0};
							link.ser_in <= wr ? wdata_i[7] : 1'b0;
							if (left == 4'h1)
								state <= SRASL_DESEL;
						end
					end
				end
			end
			SRASL_DESEL: if (tick) begin
				link.chip_sel_n <= 1'b1;
				link.ser_clk <= 1'b0;
				state <= SRASL_IDLE;
			end
			default: state <= SRASL_IDLE;
			endcase
		end
	end
endmodule : srasl_host

// ---- tb/srasl_chk.sv ----
`timescale 1ns/1ps
module srasl_chk (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// link signals
	input wire logic ser_clk,
	input wire logic chip_sel_n,
	input wire logic ser_in,
	input wire logic ser_out,
	input wire logic ser_out_oe
);
	logic [7:0] bits;
	logic [2:0] cmd;
	logic [3:0] age;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	// ----
	// frame tracking
	// ----
	// restart per frame
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			bits <= 8'h00;
			cmd <= 3'h0;
		end else if (chip_sel_n) begin
			bits <= 8'h00;
		end else if ($rose(ser_clk)) begin
			bits <= bits + 8'h01;
			if (bits < 8'h03) begin
				cmd <= {cmd[1:0], ser_in};
			end
		end
	end
	// cycles since the clock last fell; saturates so idle time is harmless
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			age <= 4'hf;
		end else if ($fell(ser_clk)) begin
			age <= 4'h0;
		end else if (age != 4'hf) begin
			age <= age + 4'h1;
		end
	end
	// ----
	// link rules
	// ----
	a_idle_clk_low: assert property (chip_sel_n |-> !ser_clk)
		else $error("clock not low while idle");
	a_clk_in_frame: assert property ($rose(ser_clk) |-> !chip_sel_n)
		else $error("clock edge outside a frame");
	a_clk_high_time: assert property ($rose(ser_clk) |=> ser_clk [*3])
		else $error("clock high phase too short");
	a_in_setup_low: assert property ($changed(ser_in) |-> !ser_clk)
		else $error("input moved while clock high");
	a_frame_whole: assert property ($rose(chip_sel_n) |->
		bits >= 8'h28 && bits[2:0] == 3'h0)
		else $error("frame not whole bytes");
	a_out_after_fall: assert property (ser_out_oe && $changed(ser_out) |->
		age < 4'h6)
		else $error("output moved away from falling edge");
	a_drive_read_only: assert property (!chip_sel_n && ser_out_oe |->
		cmd == 3'h3 && bits >= 8'h1b)
		else $error("output driven outside read data");
	a_read_drives: assert property (!chip_sel_n && cmd == 3'h3 &&
		bits == 8'h20 && $fell(ser_clk) |-> ##[0:5] ser_out_oe)
		else $error("read data not driven");
	a_desel_float: assert property (chip_sel_n [*5] |-> !ser_out_oe)
		else $error("output driven while deselected");
endmodule : srasl_chk

// ---- tb/spi_register_access_slave_bench.sv ----
`timescale 1ns/1ps
module spi_register_access_slave_bench;
	import srasl_pkg::*;
	logic clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic req_i = 1'b0;
	logic wr_i = 1'b0;
	logic [15:0] addr_i = 16'h0000;
	logic [3:0] nbytes_i = 4'h0;
	logic [7:0] wdata_i = 8'h00;
	logic busy_o;
	logic rdata_valid_o;
	logic wr_pulse_o;
	logic [7:0] rdata_o;
	logic [7:0] wr_data_o;
	logic [15:0] wr_addr_o;
	logic [1:0] port_mode_o;
	logic [1:0] strap = MODE_SERIAL;
	logic wdata_take_o;
	logic [7:0] exp_q[$];
	logic [15:0] exp_wa = 16'h0000;
	int fails = 0;
	int samples_checked = 0;
	int cycles = 0;
	srasl_if link_if();
	srasl_host srasl_host_inst(.clk_i(clk_i), .reset_n_i(reset_n_i),
		.link(link_if), .req_i(req_i), .wr_i(wr_i), .addr_i(addr_i),
		.nbytes_i(nbytes_i), .wdata_i(wdata_i), .wdata_take_o(wdata_take_o),
		.busy_o(busy_o), .rdata_valid_o(rdata_valid_o), .rdata_o(rdata_o));
	srasl_dev srasl_dev_inst(.clk_i(clk_i), .reset_n_i(reset_n_i),
		.link(link_if), .mode_strap_i(strap),
		.port_mode_o(port_mode_o), .wr_pulse_o(wr_pulse_o),
		.wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o));
	srasl_chk srasl_chk_inst(.clk_i(clk_i), .reset_n_i(reset_n_i),
		.ser_clk(link_if.ser_clk), .chip_sel_n(link_if.chip_sel_n),
		.ser_in(link_if.ser_in), .ser_out(link_if.ser_out),
		.ser_out_oe(link_if.ser_out_oe));
	always #20 clk_i = ~clk_i;
	// ----
	// tasks
	// ----
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check
	task automatic wrap_up;
		$display("compares %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : wrap_up
	// one access; waits until every byte expected has shown up
	task automatic access(input logic w, input logic [15:0] a,
		input logic [3:0] n, input logic [7:0] d);
		int k;
		logic [15:0] last;
		k = 0;
		last = w ? a + {12'h000, n} : a;
		exp_wa = a;
		@(posedge clk_i);
		req_i <= 1'b1;
		wr_i <= w;
		addr_i <= a;
		nbytes_i <= n;
		wdata_i <= d;
		@(negedge clk_i);
		check({15'h0000, wdata_take_o}, {15'h0000, w});
		@(posedge clk_i);
		req_i <= 1'b0;
		@(negedge clk_i);
		while ((busy_o !== 1'b0 || exp_q.size() != 0 || exp_wa !== last)
			&& k < 2000) begin
			@(negedge clk_i);
			k++;
		end
		check({15'h0000, k >= 2000}, 16'h0000);
		// the device sees select rise only after its synchroniser
		repeat (3) @(negedge clk_i);
		check(exp_wa, last);
		check(16'(exp_q.size()), 16'h0000);
		check({14'h0000, link_if.chip_sel_n, link_if.ser_out_oe},
			16'h0002);
	endtask : access
	// ----
	// monitors and timeout
	// ----
	always @(negedge clk_i) begin
		if (wr_pulse_o === 1'b1) begin
			check(wr_addr_o, exp_wa);
			check({8'h00, wr_data_o}, {8'h00, wdata_i});
			exp_wa = exp_wa + 16'h0001;
		end
		if (rdata_valid_o === 1'b1) begin
			check({8'h00, rdata_o}, {8'h00, exp_q.pop_front()});
		end
	end
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			wrap_up();
		end
	end
	// ----
	// sequence
	// ----
	initial begin
		repeat (4) @(posedge clk_i);
		reset_n_i <= 1'b1;
		repeat (2) @(negedge clk_i);
		check({14'h0000, port_mode_o}, {14'h0000, MODE_SERIAL});
		access(1'b1, 16'h1234, 4'h1, 8'ha5);
		access(1'b1, 16'h1235, 4'h1, 8'h3c);
		exp_q.push_back(8'ha5);
		exp_q.push_back(8'h3c);
		access(1'b0, 16'h1234, 4'h2, 8'h00);
		// address carry across the low byte on a burst
		access(1'b1, 16'h00fe, 4'h3, 8'h5a);
		repeat (3) exp_q.push_back(8'h5a);
		access(1'b0, 16'h00fe, 4'h3, 8'h00);
		// second reset with a non-serial strap: the port must stay inert
		@(posedge clk_i);
		reset_n_i <= 1'b0;
		strap <= MODE_TWO_WIRE;
		repeat (4) @(posedge clk_i);
		reset_n_i <= 1'b1;
		repeat (2) @(negedge clk_i);
		check({14'h0000, port_mode_o}, {14'h0000, MODE_TWO_WIRE});
		// one byte is framed; any committed write would move exp_wa
		access(1'b1, 16'h0040, 4'h0, 8'h77);
		wrap_up();
	end
endmodule : spi_register_access_slave_bench
